/* File: verilog/ddio_pkg.sv */
// Constants, register map and field layout for the 96-line digital I/O block.
//
// Behaviour
// [RULE_01] Ninety-six lines arranged as four independent groups of twenty-four.
// [RULE_02] Each group: two byte ports plus a third port with independently directed nibbles.
// [RULE_03] Power-up and every reset leave all ninety-six lines as undriven inputs.
// [RULE_04] Interrupt control region is accessed only with full 32-bit words.
// [RULE_05] Host need not touch the bridge configuration region; operation never depends on it.
// [RULE_06] Group n registers sit at digital I/O byte offsets 4n through 4n+3.
// [RULE_07] Host keeps the compatibility-mode bit 12 of the control/status register at one.
// [RULE_08] Bit 8 picks interrupt trigger: zero level (default), one edge.
// [RULE_09] Writing one to bit 10 clears a pending interrupt, in edge mode only.
// [RULE_10] Configuration code 9b hex sets all four port sections of a group to input.
package ddio_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int GROUPS          = 4;
   localparam int GROUP_LINES     = 24;
   localparam int LINES           = GROUPS * GROUP_LINES;

   // ----------------------------------------------------------------
   // Regions and offsets
   // ----------------------------------------------------------------
   localparam logic       REGION_INTCTL   = 1'h0;
   localparam logic       REGION_DIO      = 1'h1;
   localparam logic [7:0] OFS_INT_CSR     = 8'h4c;
   localparam logic [7:0] DIO_GROUP_SPAN  = 8'h04;
   localparam logic [7:0] DIO_LAST_OFS    = 8'h0f;
   localparam logic [1:0] SUB_PORT_A      = 2'h0;
   localparam logic [1:0] SUB_PORT_B      = 2'h1;
   localparam logic [1:0] SUB_PORT_C      = 2'h2;
   localparam logic [1:0] SUB_CONFIG      = 2'h3;
   localparam logic [3:0] BE_FULL_WORD    = 4'hf;

   // ----------------------------------------------------------------
   // Group configuration byte
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_ALL_INPUT   = 8'h9b;
   localparam int         CFG_MODE_SET    = 7;
   localparam int         CFG_A_IN        = 4;
   localparam int         CFG_CU_IN       = 3;
   localparam int         CFG_B_IN        = 1;
   localparam int         CFG_CL_IN       = 0;
   localparam int         BSR_SEL_LSB     = 1;
   localparam int         BSR_VALUE       = 0;

   // ----------------------------------------------------------------
   // Interrupt control/status fields
   // ----------------------------------------------------------------
   localparam int         CSR_LOCAL_EN    = 0;
   localparam int         CSR_POLARITY    = 1;
   localparam int         CSR_INT_ACTIVE  = 2;
   localparam int         CSR_PCI_EN      = 6;
   localparam int         CSR_EDGE_MODE   = 8;
   localparam int         CSR_EDGE_CLEAR  = 10;
   localparam int         CSR_COMPAT_MODE = 12;
   localparam logic       RST_LOCAL_EN    = 1'h1;
   localparam logic       RST_POLARITY    = 1'h0;
   localparam logic       RST_PCI_EN      = 1'h0;
   localparam logic       RST_EDGE_MODE   = 1'h0;
   localparam logic       RST_COMPAT_MODE = 1'h1;

endpackage : ddio_pkg

/* File: verilog/ddio_group.sv */
// One 24-line port group: three ports, configuration byte and line synchronisers.
module ddio_group
   import ddio_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   input  wire logic                   wr_en,
   input  wire logic [1:0]             sub_addr,
   input  wire logic [7:0]             wdata,
   output logic      [7:0]             rdata,
   input  wire logic [GROUP_LINES-1:0] line_in,
   output logic      [GROUP_LINES-1:0] line_out,
   output logic      [GROUP_LINES-1:0] line_oe
);

   logic [GROUP_LINES-1:0] sync1_q;
   logic [GROUP_LINES-1:0] sync2_q;
   logic [7:0]             cfg_q;
   logic [7:0]             port_a_q;
   logic [7:0]             port_b_q;
   logic [7:0]             port_c_q;
   logic [7:0]             c_set_mask;
   logic [7:0]             c_read;

   // ----------------------------------------------------------------
   // Line synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= line_in;
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Configuration
   // ----------------------------------------------------------------
   // A byte with the mode-set bit clear is a port C single-bit command and
   // leaves the directions alone.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         cfg_q <= CFG_ALL_INPUT; // RULE_03
      else if (wr_en && sub_addr == SUB_CONFIG && wdata[CFG_MODE_SET])
         cfg_q <= wdata; // RULE_10
   end

   // ----------------------------------------------------------------
   // Output latches
   // ----------------------------------------------------------------
   assign c_set_mask = 8'h01 << wdata[BSR_SEL_LSB +: 3];

   // A mode set clears every output latch so a direction change never
   // drives stale data onto the field lines.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         port_a_q <= '0;
         port_b_q <= '0;
         port_c_q <= '0;
      end
      else if (wr_en)
      begin
         case (sub_addr)
            SUB_PORT_A: port_a_q <= wdata;
            SUB_PORT_B: port_b_q <= wdata;
            SUB_PORT_C: port_c_q <= wdata;
            default:
            begin
               if (wdata[CFG_MODE_SET])
               begin
                  port_a_q <= '0;
                  port_b_q <= '0;
                  port_c_q <= '0;
               end
               else if (wdata[BSR_VALUE])
                  port_c_q <= port_c_q | c_set_mask;
               else
                  port_c_q <= port_c_q & ~c_set_mask;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Drivers: each section follows its own direction bit
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         line_out <= '0;
         line_oe  <= '0; // RULE_03
      end
      else
      begin
         line_out <= {port_c_q, port_b_q, port_a_q};
         line_oe  <= {{4{~cfg_q[CFG_CU_IN]}}, {4{~cfg_q[CFG_CL_IN]}},
                      {8{~cfg_q[CFG_B_IN]}}, {8{~cfg_q[CFG_A_IN]}}}; // RULE_02
      end
   end

   // ----------------------------------------------------------------
   // Read back: inputs show the pins, outputs show the latch
   // ----------------------------------------------------------------
   assign c_read = {cfg_q[CFG_CU_IN] ? sync2_q[23:20] : port_c_q[7:4],
                    cfg_q[CFG_CL_IN] ? sync2_q[19:16] : port_c_q[3:0]}; // RULE_02

   always_comb
   begin
      case (sub_addr)
         SUB_PORT_A: rdata = cfg_q[CFG_A_IN] ? sync2_q[7:0]  : port_a_q;
         SUB_PORT_B: rdata = cfg_q[CFG_B_IN] ? sync2_q[15:8] : port_b_q;
         SUB_PORT_C: rdata = c_read;
         default:    rdata = cfg_q;
      endcase
   end

endmodule // ddio_group

/* File: verilog/ddio_top.sv */
// Top of the 96-line digital I/O block: local access port, interrupt CSR, four groups.
module ddio_top
(
   input  wire logic                 core_clk,
   input  wire logic                 resetn,
   input  wire logic                 acc_valid,
   input  wire logic                 acc_write,
   input  wire logic                 acc_region,
   input  wire logic [7:0]           acc_addr,
   input  wire logic [3:0]           acc_be,
   input  wire logic [31:0]          acc_wdata,
   output logic      [31:0]          rd_data,
   output logic                      rd_valid,
   input  wire logic [ddio_pkg::LINES-1:0] dio_in,
   output logic      [ddio_pkg::LINES-1:0] dio_out,
   output logic      [ddio_pkg::LINES-1:0] dio_oe,
   input  wire logic                 irq_src,
   output logic                      pci_int_n
);
   import ddio_pkg::*;

   logic                 dio_hit;
   logic [1:0]           grp_sel;
   logic [GROUPS-1:0]    grp_wr;
   logic [7:0]           grp_rdata [GROUPS];
   logic                 csr_hit;
   logic                 csr_wr;
   logic                 irq_s1_q;
   logic                 irq_s2_q;
   logic                 irq_prev_q;
   logic                 irq_level;
   logic                 local_en_q;
   logic                 polarity_q;
   logic                 pci_en_q;
   logic                 edge_mode_q;
   logic                 compat_q;
   logic                 latched_q;
   logic                 int_active;
   logic [31:0]          csr_word;
   logic [31:0]          rd_d;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // The group slicing assumes two byte ports and two nibble halves, so
   // a group of any other width cannot be served.
   if (GROUP_LINES != 32'h18)
   begin : g_bad_group_lines
      $error("A port group must hold twenty-four lines.");
   end

   // The group select is two offset bits wide, so the decode reaches at
   // most four groups.
   if (GROUPS < 32'h1 || GROUPS > 32'h4)
   begin : g_bad_groups
      $error("The group count must lie between one and four.");
   end

   // Every group takes four byte offsets: three ports and a configuration byte.
   if (int'(DIO_LAST_OFS) != GROUPS * int'(DIO_GROUP_SPAN) - 32'h1)
   begin : g_bad_last_ofs
      $error("The last digital offset does not match the group count.");
   end

   // The status register is only written with whole aligned words; reads ignore the byte enables.
   if (OFS_INT_CSR[1:0] != 2'h0)
   begin : g_bad_csr_ofs
      $error("The status register offset must be word aligned.");
   end

   if (LINES != GROUPS * GROUP_LINES)
   begin : g_bad_lines
      $error("The line count must be the group count times the group width.");
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Byte enables are ignored here: every digital register is one byte wide.
   assign dio_hit = acc_valid && acc_region == REGION_DIO && acc_addr <= DIO_LAST_OFS;
   assign grp_sel = acc_addr[3:2]; // RULE_06
   // The bridge configuration region is not decoded at all, so nothing here
   // waits on the host to program it.
   assign csr_hit = acc_valid && acc_region == REGION_INTCTL && acc_addr == OFS_INT_CSR;
   // Partial-word writes to the CSR are dropped rather than merged.
   assign csr_wr  = csr_hit && acc_write && acc_be == BE_FULL_WORD; // RULE_04

   // ----------------------------------------------------------------
   // Port groups
   // ----------------------------------------------------------------
   for (genvar g = 0; g < GROUPS; g++)
   begin : g_grp
      assign grp_wr[g] = dio_hit && acc_write && grp_sel == 2'(g); // RULE_06

      ddio_group u_grp
      (
         .core_clk (core_clk),
         .resetn   (resetn),
         .wr_en    (grp_wr[g]),
         .sub_addr (acc_addr[1:0]),
         .wdata    (acc_wdata[7:0]),
         .rdata    (grp_rdata[g]),
         .line_in  (dio_in[g*GROUP_LINES +: GROUP_LINES]),
         .line_out (dio_out[g*GROUP_LINES +: GROUP_LINES]),
         .line_oe  (dio_oe[g*GROUP_LINES +: GROUP_LINES])
      ); // RULE_01
   end

   // ----------------------------------------------------------------
   // Interrupt source synchroniser and edge capture
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_s1_q   <= 1'b0;
         irq_s2_q   <= 1'b0;
         irq_prev_q <= 1'b0;
      end
      else
      begin
         irq_s1_q   <= irq_src;
         irq_s2_q   <= irq_s1_q;
         irq_prev_q <= irq_level;
      end
   end

   // Edge mode expects the polarity bit set to active high; with it clear the
   // latch catches the falling edge of the source instead.
   assign irq_level = polarity_q ? irq_s2_q : ~irq_s2_q;

   // ----------------------------------------------------------------
   // Interrupt control/status register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         local_en_q  <= RST_LOCAL_EN;
         polarity_q  <= RST_POLARITY;
         pci_en_q    <= RST_PCI_EN;
         edge_mode_q <= RST_EDGE_MODE; // RULE_08
         compat_q    <= RST_COMPAT_MODE;
      end
      else if (csr_wr)
      begin
         local_en_q  <= acc_wdata[CSR_LOCAL_EN];
         polarity_q  <= acc_wdata[CSR_POLARITY];
         pci_en_q    <= acc_wdata[CSR_PCI_EN];
         edge_mode_q <= acc_wdata[CSR_EDGE_MODE]; // RULE_08
         // Stored and read back only; host software is expected to keep it set.
         compat_q    <= acc_wdata[CSR_COMPAT_MODE]; // RULE_07
      end
   end

   // A new edge in the clearing cycle wins, so no event is lost.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         latched_q <= 1'b0;
      else if (!edge_mode_q)
         latched_q <= 1'b0;
      else if (irq_level && !irq_prev_q)
         latched_q <= 1'b1;
      else if (csr_wr && acc_wdata[CSR_EDGE_CLEAR])
         latched_q <= 1'b0; // RULE_09
   end

   assign int_active = edge_mode_q ? latched_q : irq_level; // RULE_08

   always_comb
   begin
      csr_word                  = '0;
      csr_word[CSR_LOCAL_EN]    = local_en_q;
      csr_word[CSR_POLARITY]    = polarity_q;
      csr_word[CSR_INT_ACTIVE]  = int_active;
      csr_word[CSR_PCI_EN]      = pci_en_q;
      csr_word[CSR_EDGE_MODE]   = edge_mode_q;
      csr_word[CSR_COMPAT_MODE] = compat_q;
   end

   // ----------------------------------------------------------------
   // Interrupt request pin
   // ----------------------------------------------------------------
   // Registered so the pin never glitches while the status bits settle.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         pci_int_n <= 1'b1;
      else
         pci_int_n <= ~(int_active && local_en_q && pci_en_q);
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Unmapped offsets read as zero; the output word holds its last value
   // between reads, so only the rd_valid cycle carries fresh data.
   always_comb
   begin
      rd_d = '0;
      if (dio_hit)
         rd_d = {24'h000000, grp_rdata[grp_sel]};
      else if (csr_hit)
         rd_d = csr_word; // RULE_04
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_data  <= '0;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= acc_valid && !acc_write;
         if (acc_valid && !acc_write)
            rd_data <= rd_d;
      end
   end

endmodule // ddio_top

/* File: bench/ddio_field_model.sv */
// Behavioural model of the external equipment on the ninety-six field lines.
module ddio_field_model
(
   input  wire logic [ddio_pkg::LINES-1:0] dio_out,
   input  wire logic [ddio_pkg::LINES-1:0] dio_oe,
   input  wire logic [ddio_pkg::LINES-1:0] ext_val,
   output logic      [ddio_pkg::LINES-1:0] dio_in
);
   import ddio_pkg::*;
   // A driven line reads back the block's own level. An undriven line shows
   // what the outside equipment applies, so a stuck enable becomes visible.
   assign dio_in = (dio_out & dio_oe) | (ext_val & ~dio_oe);
endmodule // ddio_field_model

/* File: bench/ddio_checker.sv */
// Port-level assertions for the digital I/O block.
module ddio_checker
(
   input wire logic                         core_clk,
   input wire logic                         resetn,
   input wire logic                         acc_valid,
   input wire logic                         acc_write,
   input wire logic                         acc_region,
   input wire logic [7:0]                   acc_addr,
   input wire logic [31:0]                  acc_wdata,
   input wire logic [31:0]                  rd_data,
   input wire logic                         rd_valid,
   input wire logic [ddio_pkg::LINES-1:0]   dio_oe
);
   import ddio_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   wire logic rd_req = acc_valid & ~acc_write;
   wire logic cfg0_wr = acc_valid & acc_write & acc_region & (acc_addr == 8'h03);
   property p_reset_idle;
      $rose(resetn) |-> dio_oe == '0;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("lines driven after reset");
   property p_read_answer;
      rd_req |=> rd_valid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_unmapped;
      rd_req && acc_region && acc_addr > 8'h0f |=> rd_data == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_dio_byte;
      rd_req && acc_region |=> rd_data[31:8] == '0;
   endproperty
   a_dio_byte: assert property (p_dio_byte) else $error("byte read has upper bits");
   property p_csr_bits;
      rd_req && !acc_region && acc_addr == 8'h4c |=> rd_data[31:13] == '0 && !rd_data[10];
   endproperty
   a_csr_bits: assert property (p_csr_bits) else $error("status reserved bits set");
   property p_cfg_out;
      cfg0_wr && acc_wdata[7:0] == 8'h80 ##1 !acc_valid |=> dio_oe[23:0] == 24'hffffff;
   endproperty
   a_cfg_out: assert property (p_cfg_out) else $error("group 0 not driving");
   property p_cfg_in;
      cfg0_wr && acc_wdata[7:0] == 8'h9b ##1 !acc_valid |=> dio_oe[23:0] == 24'h0;
   endproperty
   a_cfg_in: assert property (p_cfg_in) else $error("group 0 not released");
   property p_grp_indep;
      acc_valid && acc_write && acc_region && acc_addr[7:2] == 6'h0 ##1 !acc_valid
         |=> $stable(dio_oe[95:24]);
   endproperty
   a_grp_indep: assert property (p_grp_indep) else $error("other groups disturbed");
endmodule // ddio_checker

/* File: bench/ddio_top_tb.sv */
// Self-checking testbench for the 96-line digital I/O block.
module ddio_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ddio_pkg::*;
   logic             core_clk, resetn, acc_valid, acc_write, acc_region, irq_src;
   logic [7:0]       acc_addr;
   logic [3:0]       acc_be;
   logic [31:0]      acc_wdata, rd_data, got;
   logic             rd_valid, pci_int_n;
   logic [LINES-1:0] dio_in, dio_out, dio_oe, ext_val;
   int               n_mismatch = 0;
   int               cmp_count = 0;

   ddio_top DUT (.core_clk(core_clk), .resetn(resetn), .acc_valid(acc_valid),
      .acc_write(acc_write), .acc_region(acc_region), .acc_addr(acc_addr), .acc_be(acc_be),
      .acc_wdata(acc_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .dio_in(dio_in),
      .dio_out(dio_out), .dio_oe(dio_oe), .irq_src(irq_src), .pci_int_n(pci_int_n));
   ddio_field_model field (.dio_out(dio_out), .dio_oe(dio_oe), .ext_val(ext_val),
      .dio_in(dio_in));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [LINES-1:0] g, input logic [LINES-1:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // One access: request held for one edge, read data taken when rd_valid is seen.
   task automatic acc(input logic w, input logic rg, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      #1;
      {acc_valid, acc_write, acc_region, acc_addr, acc_be, acc_wdata} = {1'b1, w, rg, a, be, d};
      @(posedge core_clk);
      #1;
      acc_valid = 1'b0;
      for (i = 0; !w && rd_valid !== 1'b1 && i < 4; i++)
         @(posedge core_clk);
      if (i == 4)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, rd_valid, 1'b1);
         conclude();
      end
      else
         got = rd_data;
   endtask

   task automatic wr(input logic rg, input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, rg, a, 4'hf, d);
   endtask

   task automatic rd(input logic rg, input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, rg, a, 4'hf, 32'h0);
      chk(got, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wait_int(input logic v);
      for (int i = 0; i < 8 && pci_int_n !== v; i++)
         settle(1);
      chk(pci_int_n, v);
   endtask

   task automatic t_reset();
      chk(dio_oe, '0);
      chk(pci_int_n, 1'b1);
      for (int g = 0; g < GROUPS; g++)
         rd(1'b1, 8'(4 * g + 3), CFG_ALL_INPUT);
      rd(1'b0, OFS_INT_CSR, 32'h1001);
   endtask

   task automatic t_groups();
      for (int g = 0; g < GROUPS; g++)
      begin
         wr(1'b1, 8'(4 * g + 3), 32'h80);
         wr(1'b1, 8'(4 * g), 32'haa);
         wr(1'b1, 8'(4 * g + 1), 32'h55);
         wr(1'b1, 8'(4 * g + 2), 32'hc3);
         settle(1);
         chk(dio_oe, {72'h0, 24'hffffff} << (24 * g));
         chk(dio_out, {72'h0, 24'hc355aa} << (24 * g));
         rd(1'b1, 8'(4 * g + 1), 32'h55);
         wr(1'b1, 8'(4 * g + 3), 32'h9b);
         settle(1);
         chk(dio_oe, '0);
      end
   endtask

   task automatic t_nibbles();
      wr(1'b1, 8'h07, 32'h81);
      wr(1'b1, 8'h06, 32'h5a);
      settle(1);
      chk(dio_oe[47:24], 24'hf0ffff);
      rd(1'b1, 8'h06, {24'h0, 4'h5, ext_val[43:40]});
      wr(1'b1, 8'h07, 32'h88);
      wr(1'b1, 8'h06, 32'h5a);
      settle(1);
      chk(dio_oe[47:24], 24'h0fffff);
      rd(1'b1, 8'h06, {24'h0, ext_val[47:44], 4'ha});
      wr(1'b1, 8'h07, 32'h01);
      rd(1'b1, 8'h06, {24'h0, ext_val[47:44], 4'hb});
      wr(1'b1, 8'h07, 32'h02);
      rd(1'b1, 8'h06, {24'h0, ext_val[47:44], 4'h9});
      rd(1'b1, 8'h07, 32'h88);
      wr(1'b1, 8'h07, 32'h9b);
      // Port A was driving zero, so the line synchronisers need time to see the pins.
      settle(3);
      rd(1'b1, 8'h04, {24'h0, ext_val[31:24]});
      rd(1'b1, 8'h10, 32'h0);
      rd(1'b0, 8'h00, 32'h0);
   endtask

   task automatic t_irq();
      irq_src = 1'b0;
      settle(3);
      acc(1'b1, 1'b0, OFS_INT_CSR, 4'h3, 32'h1143);
      rd(1'b0, OFS_INT_CSR, 32'h1005);
      wr(1'b0, OFS_INT_CSR, 32'h1143);
      rd(1'b0, OFS_INT_CSR, 32'h1143);
      irq_src = 1'b1;
      wait_int(1'b0);
      irq_src = 1'b0;
      settle(4);
      chk(pci_int_n, 1'b0);
      wr(1'b0, OFS_INT_CSR, 32'h1543);
      wait_int(1'b1);
      wr(1'b0, OFS_INT_CSR, 32'h1043);
      irq_src = 1'b1;
      wait_int(1'b0);
      wr(1'b0, OFS_INT_CSR, 32'h1443);
      settle(3);
      chk(pci_int_n, 1'b0);
      irq_src = 1'b0;
      wait_int(1'b1);
   endtask

   // A reset in mid-run must drop every driver at once, without a clock edge.
   task automatic t_rerun();
      wr(1'b1, 8'h0b, 32'h80);
      settle(1);
      resetn = 1'b0;
      #2;
      chk(dio_oe, '0);
      settle(1);
      resetn = 1'b1;
      rd(1'b1, 8'h0b, 32'h9b);
   endtask

   initial
   begin
      {resetn, acc_valid, acc_write, acc_region, irq_src} = 5'b00001;
      acc_addr = 8'h00;
      acc_be = 4'h0;
      acc_wdata = 32'h0;
      ext_val = 96'h3c96_a5e1_d24b_7f08_19c6_e5b3;
      settle(6);
      resetn = 1'b1;
      t_reset();
      t_groups();
      t_nibbles();
      t_irq();
      t_rerun();
      conclude();
   end
endmodule // ddio_top_tb

bind ddio_top ddio_checker u_chk (.core_clk(core_clk), .resetn(resetn), .acc_valid(acc_valid),
   .acc_write(acc_write), .acc_region(acc_region), .acc_addr(acc_addr),
   .acc_wdata(acc_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .dio_oe(dio_oe));
